// ==== rtl/amc_cfg.svh ====
`ifndef AMC_CFG_SVH
`define AMC_CFG_SVH

// register byte addresses on the special-function bus
`define AMC_ADDR_PAIR_CFG 8'hba
`define AMC_ADDR_CHAN_SEL 8'hbb
`define AMC_ADDR_CLK_GAIN 8'hbc

// reset values
`define AMC_RST_PAIR_CFG 4'h0
`define AMC_RST_CHAN_SEL 4'h0
`define AMC_RST_CLK_GAIN 8'hf8

// field positions
`define AMC_DIV_MSB 7
`define AMC_DIV_LSB 3
`define AMC_GAIN_MSB 2
`define AMC_GAIN_LSB 0
`define AMC_LOW_MSB 3
`define AMC_TEMP_BIT 3

// sequencer lengths in sar clock periods
`define AMC_TRACK_SAR_CLKS 5'h03
`define AMC_CONV_SAR_CLKS 5'h10

// system clock and settling
`define AMC_CLK_PERIOD_NS 20
`define AMC_SETTLE_NS 1500
`define AMC_SETTLE_CYC \
    ((`AMC_SETTLE_NS + `AMC_CLK_PERIOD_NS - 1) / `AMC_CLK_PERIOD_NS)

// sar clock ceiling
`define AMC_SYS_KHZ 50000
`define AMC_SAR_MAX_KHZ 2500
`define AMC_SAR_MIN_DIV ((`AMC_SYS_KHZ / (2 * `AMC_SAR_MAX_KHZ)) - 1)

`endif

// ==== rtl/amc_pkg.sv ====
package amc_pkg;

    // analog multiplexer selection
    typedef struct packed {
        logic temp_sel;
        logic differential;
        logic [2:0] pos_idx;
        logic [2:0] neg_idx;
    } amc_mux_sel_s;

    // decoded amplifier gain, one bit per setting
    typedef enum logic [5:0] {
        AMC_GAIN_X1 = 6'h01,
        AMC_GAIN_X2 = 6'h02,
        AMC_GAIN_X4 = 6'h04,
        AMC_GAIN_X8 = 6'h08,
        AMC_GAIN_X16 = 6'h10,
        AMC_GAIN_HALF = 6'h20
    } amc_gain_e;

    // conversion sequencer states
    typedef enum logic [2:0] {
        AMC_ST_IDLE = 3'h1,
        AMC_ST_TRACK = 3'h2,
        AMC_ST_CONV = 3'h4
    } amc_state_e;

endpackage

// ==== rtl/amc_mux_decode.sv ====
`timescale 1ns/100ps
module amc_mux_decode
    import amc_pkg::*;
(
    // configuration
    input wire logic [3:0] pair_cfg_in,
    input wire logic [3:0] channel_code_in,
    // resulting selection
    output amc_mux_sel_s mux_sel_out
);

    // channel code plus pair modes to input selection
    always_comb
    begin
        logic [1:0] pair;
        pair = channel_code_in[2:1];
        mux_sel_out = '0;
        mux_sel_out.temp_sel = channel_code_in[3]; // R06
        if (!channel_code_in[3] && pair_cfg_in[pair])
        begin
            // either code of a differential pair gives +even / -odd
            mux_sel_out.differential = 1'b1; // R07 R14
            mux_sel_out.pos_idx = {pair, 1'b0}; // R04
            mux_sel_out.neg_idx = {pair, 1'b1}; // R04
        end
        else if (!channel_code_in[3])
        begin
            // single-ended input chosen directly by the code
            mux_sel_out.pos_idx = channel_code_in[2:0]; // R06
        end
    end

endmodule // amc_mux_decode

// ==== rtl/amc_sar_div.sv ====
`timescale 1ns/100ps
module amc_sar_div
#(
    parameter int DIV_W = 5
)
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // divider setting
    input wire logic [DIV_W-1:0] div_in,
    // one pulse per sar clock period
    output logic tick_out
);

    logic [DIV_W:0] cnt_r; // system cycles within the period
    logic [DIV_W:0] cnt_nxt;
    logic tick_r; // registered period pulse
    logic tick_nxt;
    logic [DIV_W:0] limit; // last count of the period, 2d+1

    assign limit = {div_in, 1'b1};
    assign tick_out = tick_r;

    // period counter next values
    always_comb
    begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (div_in == '0)
        begin
            // undivided: sar clock runs at the system rate
            cnt_nxt = '0; // R10
            tick_nxt = 1'b1; // R10
        end
        else if (cnt_r >= limit)
        begin
            // period of 2*(d+1) system cycles complete
            cnt_nxt = '0; // R09
            tick_nxt = 1'b1; // R09
        end
        else
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // period counter registers
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // helper: cycles since last tick, and divider held steady since
    logic [DIV_W+1:0] gap_r;
    logic stab_r;
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gap_r <= '0;
            stab_r <= 1'b0;
        end
        else
        begin
            gap_r <= tick_r ? '0 : gap_r + 1'b1;
            stab_r <= tick_r ? 1'b1 : (stab_r && $stable(div_in));
        end
    end

    chk_div_period: assert property ( // R09
        @(posedge ref_clk_in) disable iff (rst_in)
        (tick_r && stab_r && $stable(div_in) && div_in != '0)
            |-> (gap_r == {1'b0, div_in, 1'b1}))
        else $error("sar tick period wrong");

    chk_div_zero: assert property ( // R10
        @(posedge ref_clk_in) disable iff (rst_in)
        (div_in == '0) |=> tick_r [*1])
        else $error("undivided sar clock missed a cycle");

endmodule // amc_sar_div

// ==== rtl/amc_conv_ctrl.sv ====
`timescale 1ns/100ps
`include "amc_cfg.svh"
// Overview of operation
// R01: low-power mode tracks three sar clocks first
// R02: software waits 1.5 us after mux/gain change
// R03: upper nibble of pair/select reads zero
// R04: pair bit k joins inputs 2k, 2k+1
// R05: differential results signed, single-ended unsigned
// R06: low codes pick input, top bit temperature
// R07: even code of differential pair measures pair
// R08: divider bits 7-3, gain bits 2-0
// R09: sar clock is system over 2(d+1)
// R10: divider zero runs sar at system rate
// R11: software keeps sar clock at most 2.5 mhz
// R12: gain codes map 1,2,4,8,16,0.5
// R13: fixed tracking only when track mode set
// R14: odd code of differential pair measures pair
module amc_conv_ctrl
    import amc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // conversion control from the control register
    input wire logic track_mode_select_in,
    input wire logic conv_start_in,
    // successive-approximation core
    input wire logic [9:0] sar_code_in,
    output logic sar_tick_out,
    output logic tracking_out,
    output logic converting_out,
    output logic busy_out,
    // analog front-end setting
    output amc_mux_sel_s mux_sel_out,
    output amc_gain_e amplifier_gain_out,
    // result and status
    output logic [15:0] result_out,
    output logic result_signed_out,
    output logic done_out,
    output logic settled_out,
    output logic sar_rate_ok_out
);

    // register file state
    logic [3:0] pair_cfg_r; // pairN_differential bits
    logic [3:0] pair_cfg_nxt;
    logic [3:0] channel_code_r; // channel_code
    logic [3:0] channel_code_nxt;
    logic [4:0] sar_clock_divider_r; // sar_clock_divider
    logic [4:0] sar_clock_divider_nxt;
    logic [2:0] amplifier_gain_code_r; // amplifier_gain_code
    logic [2:0] amplifier_gain_code_nxt;
    logic [7:0] rdata_r; // read data, valid one cycle after strobe
    logic [7:0] rdata_nxt;

    // address decode
    logic hit_pair;
    logic hit_chan;
    logic hit_cfg;
    assign hit_pair = (reg_addr_in == `AMC_ADDR_PAIR_CFG);
    assign hit_chan = (reg_addr_in == `AMC_ADDR_CHAN_SEL);
    assign hit_cfg = (reg_addr_in == `AMC_ADDR_CLK_GAIN);

    // register writes and read mux
    always_comb
    begin
        pair_cfg_nxt = pair_cfg_r;
        channel_code_nxt = channel_code_r;
        sar_clock_divider_nxt = sar_clock_divider_r;
        amplifier_gain_code_nxt = amplifier_gain_code_r;
        rdata_nxt = 8'h00;
        if (reg_wr_in)
        begin
            // upper nibble of pair and select writes dropped
            if (hit_pair)
                pair_cfg_nxt = reg_wdata_in[`AMC_LOW_MSB:0]; // R03 R04
            if (hit_chan)
                channel_code_nxt = reg_wdata_in[`AMC_LOW_MSB:0]; // R03 R06
            if (hit_cfg)
            begin
                sar_clock_divider_nxt =
                    reg_wdata_in[`AMC_DIV_MSB:`AMC_DIV_LSB]; // R08
                amplifier_gain_code_nxt =
                    reg_wdata_in[`AMC_GAIN_MSB:`AMC_GAIN_LSB]; // R08
            end
        end
        if (reg_rd_in)
        begin
            // unmapped addresses read zero
            if (hit_pair)
                rdata_nxt = {4'h0, pair_cfg_r}; // R03
            else if (hit_chan)
                rdata_nxt = {4'h0, channel_code_r}; // R03
            else if (hit_cfg)
                rdata_nxt = {sar_clock_divider_r,
                             amplifier_gain_code_r}; // R08
        end
    end

    // register file flops
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pair_cfg_r <= `AMC_RST_PAIR_CFG;
            channel_code_r <= `AMC_RST_CHAN_SEL;
            sar_clock_divider_r <=
                5'(`AMC_RST_CLK_GAIN >> `AMC_DIV_LSB);
            amplifier_gain_code_r <= 3'(`AMC_RST_CLK_GAIN);
            rdata_r <= 8'h00;
        end
        else
        begin
            pair_cfg_r <= pair_cfg_nxt;
            channel_code_r <= channel_code_nxt;
            sar_clock_divider_r <= sar_clock_divider_nxt;
            amplifier_gain_code_r <= amplifier_gain_code_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign reg_rdata_out = rdata_r;

    // multiplexer decode, registered on the way out
    amc_mux_sel_s mux_dec;
    amc_mux_sel_s mux_sel_r;
    amc_mux_decode u_mux_decode (
        .pair_cfg_in(pair_cfg_r),
        .channel_code_in(channel_code_r),
        .mux_sel_out(mux_dec)
    );

    // amplifier gain decode
    amc_gain_e gain_r;
    amc_gain_e gain_nxt;
    always_comb
    begin
        unique casez (amplifier_gain_code_r) // R12
            3'b000: gain_nxt = AMC_GAIN_X1;
            3'b001: gain_nxt = AMC_GAIN_X2;
            3'b010: gain_nxt = AMC_GAIN_X4;
            3'b011: gain_nxt = AMC_GAIN_X8;
            3'b10?: gain_nxt = AMC_GAIN_X16;
            default: gain_nxt = AMC_GAIN_HALF;
        endcase
    end

    // front-end setting flops
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mux_sel_r <= '0;
            // matches gain code 000 held in reset: unity
            gain_r <= AMC_GAIN_X1;
        end
        else
        begin
            mux_sel_r <= mux_dec;
            gain_r <= gain_nxt;
        end
    end
    assign mux_sel_out = mux_sel_r;
    assign amplifier_gain_out = gain_r;

    // sar conversion clock divider
    logic sar_tick;
    amc_sar_div #(.DIV_W(5)) u_sar_div (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .div_in(sar_clock_divider_r),
        .tick_out(sar_tick)
    );
    assign sar_tick_out = sar_tick;
    // flag for software that the sar clock is within its ceiling
    assign sar_rate_ok_out =
        (sar_clock_divider_r >= 5'(`AMC_SAR_MIN_DIV)); // R11

    // conversion sequencer state
    amc_state_e state_r;
    amc_state_e state_nxt;
    logic [4:0] tcnt_r; // sar clocks spent in current phase
    logic [4:0] tcnt_nxt;
    logic [15:0] result_r;
    logic [15:0] result_nxt;
    logic signed_r; // format latched at start
    logic signed_nxt;
    logic done_r;
    logic done_nxt;

    // sequencer next state; starts while busy are ignored
    always_comb
    begin
        state_nxt = state_r;
        tcnt_nxt = tcnt_r;
        result_nxt = result_r;
        signed_nxt = signed_r;
        done_nxt = 1'b0;
        unique case (state_r)
            AMC_ST_IDLE:
            begin
                if (conv_start_in)
                begin
                    tcnt_nxt = 5'h00;
                    signed_nxt = mux_sel_r.differential &&
                                 !mux_sel_r.temp_sel; // R05
                    // fixed tracking only in low-power mode
                    state_nxt = track_mode_select_in ?
                        AMC_ST_TRACK : AMC_ST_CONV; // R13
                end
            end
            AMC_ST_TRACK:
            begin
                if (sar_tick)
                begin
                    if (tcnt_r == `AMC_TRACK_SAR_CLKS - 5'h01)
                    begin
                        tcnt_nxt = 5'h00;
                        state_nxt = AMC_ST_CONV; // R01
                    end
                    else
                        tcnt_nxt = tcnt_r + 5'h01; // R01
                end
            end
            AMC_ST_CONV:
            begin
                if (sar_tick)
                begin
                    if (tcnt_r == `AMC_CONV_SAR_CLKS - 5'h01)
                    begin
                        // sign-extend a differential code
                        result_nxt = signed_r ?
                            {{6{sar_code_in[9]}}, sar_code_in} :
                            {6'h00, sar_code_in}; // R05
                        done_nxt = 1'b1;
                        tcnt_nxt = 5'h00;
                        state_nxt = AMC_ST_IDLE;
                    end
                    else
                        tcnt_nxt = tcnt_r + 5'h01;
                end
            end
        endcase
    end

    // sequencer flops
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r <= AMC_ST_IDLE;
            tcnt_r <= 5'h00;
            result_r <= 16'h0000;
            signed_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            tcnt_r <= tcnt_nxt;
            result_r <= result_nxt;
            signed_r <= signed_nxt;
            done_r <= done_nxt;
        end
    end
    assign tracking_out = (state_r == AMC_ST_TRACK);
    assign converting_out = (state_r == AMC_ST_CONV);
    assign busy_out = (state_r != AMC_ST_IDLE);
    assign result_out = result_r;
    assign result_signed_out = signed_r;
    assign done_out = done_r;

    // settling timer restarted by any mux or gain change
    logic [6:0] settle_r;
    logic [6:0] settle_nxt;
    always_comb
    begin
        settle_nxt = settle_r;
        if ((pair_cfg_nxt != pair_cfg_r) ||
            (channel_code_nxt != channel_code_r) ||
            (amplifier_gain_code_nxt != amplifier_gain_code_r))
            settle_nxt = 7'(`AMC_SETTLE_CYC); // R02
        else if (settle_r != 7'h00)
            settle_nxt = settle_r - 7'h01;
    end

    // settling timer flop; reset counts as a change
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            settle_r <= 7'(`AMC_SETTLE_CYC);
        else
            settle_r <= settle_nxt;
    end
    assign settled_out = (settle_r == 7'h00);

    // helper: sar ticks seen while tracking
    logic [4:0] trk_ticks_r;
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            trk_ticks_r <= 5'h00;
        else if (state_r == AMC_ST_IDLE)
            trk_ticks_r <= 5'h00;
        else if (state_r == AMC_ST_TRACK && sar_tick)
            trk_ticks_r <= trk_ticks_r + 5'h01;
    end

    chk_track_len: assert property ( // R01
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_r == AMC_ST_CONV && $past(state_r) == AMC_ST_TRACK)
            |-> (trk_ticks_r == `AMC_TRACK_SAR_CLKS))
        else $error("tracking phase length wrong");

    chk_track_skip: assert property ( // R13
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_r == AMC_ST_IDLE && conv_start_in && !track_mode_select_in)
            |=> (state_r == AMC_ST_CONV))
        else $error("tracking entered without track mode");

    chk_rsv_read: assert property ( // R03
        @(posedge ref_clk_in) disable iff (rst_in)
        (reg_rd_in && (hit_pair || hit_chan))
            |=> (reg_rdata_out[7:4] == 4'h0))
        else $error("reserved bits read nonzero");

    chk_cfg_write: assert property ( // R08
        @(posedge ref_clk_in) disable iff (rst_in)
        (reg_wr_in && hit_cfg) ##1 (reg_rd_in && hit_cfg && !reg_wr_in)
            |=> (reg_rdata_out == $past(reg_wdata_in, 2)))
        else $error("config register readback mismatch");

    chk_diff_even: assert property ( // R07
        @(posedge ref_clk_in) disable iff (rst_in)
        (!channel_code_r[3] && pair_cfg_r[channel_code_r[2:1]])
            |=> (mux_sel_r.differential &&
                 mux_sel_r.pos_idx == {$past(channel_code_r[2:1]), 1'b0}))
        else $error("differential pair not selected");

    chk_temp_sel: assert property ( // R06
        @(posedge ref_clk_in) disable iff (rst_in)
        channel_code_r[`AMC_TEMP_BIT]
            |=> (mux_sel_r.temp_sel && !mux_sel_r.differential))
        else $error("temperature sensor not selected");

    chk_sign_ext: assert property ( // R05
        @(posedge ref_clk_in) disable iff (rst_in)
        done_r |-> (result_signed_out ?
            (result_out[15:10] == {6{result_out[9]}}) :
            (result_out[15:10] == 6'h00)))
        else $error("result format wrong");

    chk_gain_map: assert property ( // R12
        @(posedge ref_clk_in) disable iff (rst_in)
        (amplifier_gain_code_r[2:1] == 2'h3)
            |=> (amplifier_gain_out == AMC_GAIN_HALF))
        else $error("gain code 11x not half");

endmodule // amc_conv_ctrl

// ==== tb/amc_analog_model.sv ====
`timescale 1ns/100ps
module amc_analog_model
    import amc_pkg::*;
(
    // selection coming from the front end
    input wire amc_mux_sel_s mux_sel_in,
    // code as the sar core would resolve it
    output logic [9:0] sar_code_out
);
    // each source gives its own level, so a wrong pick shows in the result
    always_comb
    begin
        if (mux_sel_in.temp_sel)
        begin
            // sensor sits near a third of full scale
            sar_code_out = 10'h155;
        end
        else if (mux_sel_in.differential)
        begin
            // pair reads negative, two's complement
            sar_code_out = {1'b1, mux_sel_in.pos_idx, 6'h2a};
        end
        else
        begin
            // single-ended level grows with the input index
            sar_code_out = {mux_sel_in.pos_idx, 7'h15};
        end
    end
endmodule // amc_analog_model

// ==== tb/amc_conv_ctrl_bench.sv ====
`timescale 1ns/100ps
`include "amc_cfg.svh"
module amc_conv_ctrl_bench
    import amc_pkg::*;
;
    // one ordinary case: writes and the outputs they should give
    typedef struct packed {
        logic [3:0] pair;
        logic [3:0] chan;
        logic [7:0] cfg;
        logic [7:0] mux;
        logic [7:0] mask;
        logic [5:0] gain;
    } amc_tb_row_s;
    logic ref_clk_in;
    logic rst_in;
    logic [7:0] reg_addr_in;
    logic [7:0] reg_wdata_in;
    logic reg_wr_in;
    logic reg_rd_in;
    logic [7:0] reg_rdata_out;
    logic track_mode_select_in;
    logic conv_start_in;
    logic [9:0] sar_code_in;
    logic sar_tick_out;
    logic tracking_out;
    logic converting_out;
    logic busy_out;
    amc_mux_sel_s mux_sel_out;
    amc_gain_e amplifier_gain_out;
    logic [15:0] result_out;
    logic result_signed_out;
    logic done_out;
    logic settled_out;
    logic sar_rate_ok_out;
    int n_fail = 0; // mismatches
    int samples_checked = 0; // comparisons made
    int cycles = 0; // run length so far
    // cases: pair, code, clock/gain byte, mux, mux mask, gain
    amc_tb_row_s rows [9] = '{
        '{4'h0, 4'h0, 8'h00, 8'h00, 8'hff, AMC_GAIN_X1},
        '{4'h0, 4'h7, 8'h09, 8'h38, 8'hff, AMC_GAIN_X2},
        '{4'h1, 4'h0, 8'h4a, 8'h41, 8'hff, AMC_GAIN_X4},
        '{4'h1, 4'h1, 8'h43, 8'h41, 8'hff, AMC_GAIN_X8},
        '{4'h1, 4'h2, 8'h04, 8'h10, 8'hff, AMC_GAIN_X16},
        '{4'h8, 4'h6, 8'h15, 8'h77, 8'hff, AMC_GAIN_X16},
        '{4'h8, 4'h7, 8'h06, 8'h77, 8'hff, AMC_GAIN_HALF},
        '{4'hf, 4'h9, 8'hff, 8'h80, 8'hc7, AMC_GAIN_HALF},
        '{4'h4, 4'h5, 8'h1a, 8'h65, 8'hff, AMC_GAIN_X4}
    };

    amc_conv_ctrl dut (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .track_mode_select_in(track_mode_select_in),
        .conv_start_in(conv_start_in),
        .sar_code_in(sar_code_in),
        .sar_tick_out(sar_tick_out),
        .tracking_out(tracking_out),
        .converting_out(converting_out),
        .busy_out(busy_out),
        .mux_sel_out(mux_sel_out),
        .amplifier_gain_out(amplifier_gain_out),
        .result_out(result_out),
        .result_signed_out(result_signed_out),
        .done_out(done_out),
        .settled_out(settled_out),
        .sar_rate_ok_out(sar_rate_ok_out)
    );

    amc_analog_model far_side (
        .mux_sel_in(mux_sel_out),
        .sar_code_out(sar_code_in)
    );

    // system clock, 20 ns period
    initial
    begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    // verdict and end of run
    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // compare one value and count it
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        check(reg_rdata_out, exp);
    endtask

    // measure the spacing of two sar ticks
    task automatic tick_period(input logic [4:0] d);
        int k;
        int p;
        k = 0;
        p = 0;
        // first tick after the divider change, then the next one
        do
        begin
            @(posedge ref_clk_in);
            #1;
            k++;
        end while (sar_tick_out !== 1'b1 && k < 200);
        do
        begin
            @(posedge ref_clk_in);
            #1;
            p++;
        end while (sar_tick_out !== 1'b1 && p < 200);
        k = (d == 5'h0) ? 1 : 2 * (int'(d) + 1);
        check(p, k);
    endtask

    // one conversion with a refused start in mid-run
    task automatic run_conv(input logic trk, input logic sg,
        input logic [9:0] code);
        int nt;
        int nc;
        int k;
        nt = 0;
        nc = 0;
        k = 0;
        @(posedge ref_clk_in);
        track_mode_select_in <= trk;
        conv_start_in <= 1'b1;
        @(posedge ref_clk_in);
        conv_start_in <= 1'b0;
        do
        begin
            #1;
            if (sar_tick_out === 1'b1 && tracking_out === 1'b1)
                nt++;
            if (sar_tick_out === 1'b1 && converting_out === 1'b1)
                nc++;
            if (done_out === 1'b1)
                break;
            @(posedge ref_clk_in);
            conv_start_in <= (k == 4);
            k++;
        end while (k < 3000);
        check(done_out, 1'b1);
        check(nt, trk ? 3 : 0);
        check(nc, 16);
        check(busy_out, 1'b0);
        check(result_signed_out, sg);
        check(result_out, sg ? {{6{code[9]}}, code}
                             : {6'h0, code});
    endtask

    // cut a hang short
    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    // main sequence
    initial
    begin
        amc_tb_row_s r;
        int n;
        logic [9:0] code; // raw code expected from the far side
        rst_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        track_mode_select_in = 1'b0;
        conv_start_in = 1'b0;
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        // reset values and an unmapped place
        reg_read(`AMC_ADDR_PAIR_CFG, 8'h00);
        reg_read(`AMC_ADDR_CHAN_SEL, 8'h00);
        reg_read(`AMC_ADDR_CLK_GAIN, 8'hf8);
        check(amplifier_gain_out, AMC_GAIN_X1);
        check(sar_rate_ok_out, 1'b1);
        reg_write(8'hbd, 8'hff);
        reg_read(8'hbd, 8'h00);
        @(posedge ref_clk_in);
        #1;
        check(reg_rdata_out, 8'h00);
        reg_read(`AMC_ADDR_CLK_GAIN, 8'hf8);
        // ordinary cases
        for (int i = 0; i < 9; i++)
        begin
            r = rows[i];
            reg_write(`AMC_ADDR_PAIR_CFG, {4'ha, r.pair});
            reg_write(`AMC_ADDR_CHAN_SEL, {4'h5, r.chan});
            reg_write(`AMC_ADDR_CLK_GAIN, r.cfg);
            reg_read(`AMC_ADDR_PAIR_CFG, {4'h0, r.pair});
            reg_read(`AMC_ADDR_CHAN_SEL, {4'h0, r.chan});
            reg_read(`AMC_ADDR_CLK_GAIN, r.cfg);
            check(mux_sel_out & r.mask, r.mux);
            check(amplifier_gain_out, r.gain);
            check(sar_rate_ok_out, r.cfg[7:3] >= 5'd9);
            tick_period(r.cfg[7:3]);
            n = 0;
            while (settled_out !== 1'b1 && n < 200)
            begin
                @(posedge ref_clk_in);
                #1;
                n++;
            end
            check(settled_out, 1'b1);
            // level that the far side gives for the expected pick
            code = r.mux[7] ? 10'h155 : (r.mux[6] ?
                {1'b1, r.mux[5:3], 6'h2a} : {r.mux[5:3], 7'h15});
            run_conv(1'(i % 2), r.mux[6] & ~r.mux[7], code);
        end
        // write then read with no gap between the strobes
        @(posedge ref_clk_in);
        reg_addr_in <= `AMC_ADDR_CLK_GAIN;
        reg_wdata_in <= 8'h5b;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        check(reg_rdata_out, 8'h5b);
        // gain change drops settled for the full 1.5 us
        reg_write(`AMC_ADDR_CLK_GAIN, 8'h01);
        repeat (2) @(posedge ref_clk_in);
        #1;
        check(settled_out, 1'b0);
        n = 0;
        while (settled_out !== 1'b1 && n < 200)
        begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        check(n >= `AMC_SETTLE_CYC - 4, 1'b1);
        // reset in the middle of a conversion
        @(posedge ref_clk_in);
        conv_start_in <= 1'b1;
        @(posedge ref_clk_in);
        conv_start_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        check(busy_out, 1'b0);
        rst_in <= 1'b0;
        reg_read(`AMC_ADDR_CLK_GAIN, 8'hf8);
        check(mux_sel_out, 8'h00);
        check(amplifier_gain_out, AMC_GAIN_X1);
        check(settled_out, 1'b0);
        tally_and_finish();
    end
endmodule // amc_conv_ctrl_bench
